// ==== dbc_pkg.sv ====
// Shared constants, types and layouts for the DMA buffer closure channel
package dbc_pkg;
   localparam int DBC_AW = 32;
   localparam int DBC_DW = 32;
   localparam int DBC_FIFO_DEPTH = 8;
   // Descriptor word offsets within one descriptor
   localparam logic [31:0] DBC_OFS_CTL = 32'h0000_0000;
   localparam logic [31:0] DBC_OFS_DST = 32'h0000_0004;
   localparam logic [31:0] DBC_OFS_NEXT = 32'h0000_0008;
   localparam logic [31:0] DBC_DESC_STEP = 32'h0000_000C;
   localparam logic [31:0] DBC_UNIT_STEP = 32'h0000_0004;
   localparam logic [31:0] DBC_CTL_RST = 32'h0000_0000;
   localparam logic [31:0] DBC_ADDR_RST = 32'h0000_0000;

   // Channel control word, same layout in registers and descriptors
   typedef struct packed {
      logic [15:0] len;
      logic [7:0] cmd_status;
      logic [2:0] rsvd;
      logic linked;
      logic link_fetch;
      logic eof_en;
      logic loop;
      logic run;
   } dbc_ctl_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [DBC_AW-1:0] addr;
      logic [DBC_DW-1:0] wdata;
   } dbc_mem_req_s;

   typedef enum logic [2:0] {
      DBC_IDLE, DBC_FETCH, DBC_MOVE, DBC_WB, DBC_LARSTEP, DBC_NEXTLAR, DBC_RELOAD
   } dbc_state_e;
endpackage : dbc_pkg

// ==== dbc_channel.sv ====
// DMA channel with buffer closure, direct and linked-list modes, and its data FIFO
`timescale 1ns/100ps

// ==========================================
// Data FIFO
module dbc_fifo
   import dbc_pkg::*;
#(
   parameter int W = DBC_DW,
   parameter int D = DBC_FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   localparam logic [CW-1:0] FULL = CW'(D);

   if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
      $error("dbc_fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } dbc_fifo_st_s;

   dbc_fifo_st_s q, d;
   logic push, pop;

   assign o_in_ready = (q.cnt != FULL);
   assign o_out_valid = (q.cnt != '0);
   assign o_out_data = q.mem[q.rp];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = i_in_data;
         d.wp = q.wp + AW'(1);
      end
      if (pop) begin
         d.rp = q.rp + AW'(1);
      end
      if (push && !pop) begin
         d.cnt = q.cnt + CW'(1);
      end else if (pop && !push) begin
         d.cnt = q.cnt - CW'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : dbc_fifo

// ==========================================
// Channel
// Behaviour
// - Closure starts when remaining transfer length reaches zero.
// - Closure also starts on a peripheral end-of-frame request.
// - Loop bit: descriptor untouched at closure; list pointer advances or reloads.
// - End-of-frame closure clears run bit; frame-end flag loads peripheral status if length not yet zero.
// - Linked-list closure with loop bit clear writes control word back to descriptor control word.
// - List pointer advances, or loads next address when link-fetch flag set.
// - Length-expiry closure clears run bit, leaves command status untouched.
// - Direct mode: software loads registers, channel stops after transfer.
// - Linked-list mode: registers loaded from descriptors, chain continues alone.
// - Descriptor words share layout with channel control and address registers.
module dbc_channel
   import dbc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_sw_load,
   input wire logic [31:0] i_sw_ctl,
   input wire logic [DBC_AW-1:0] i_sw_dst,
   input wire logic [DBC_AW-1:0] i_sw_lar,
   output logic [31:0] o_channel_control_word,
   output logic [DBC_AW-1:0] o_dst,
   output logic [DBC_AW-1:0] o_list_address_pointer,
   output logic o_busy,
   output logic o_closed,
   input wire logic i_per_valid,
   input wire logic [DBC_DW-1:0] i_per_data,
   output logic o_per_ready,
   input wire logic i_per_eof,
   input wire logic [7:0] i_per_status,
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [DBC_AW-1:0] o_mem_addr,
   output logic [DBC_DW-1:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [DBC_DW-1:0] i_mem_rdata
);
   typedef struct packed {
      dbc_state_e st;
      dbc_ctl_s ctl;
      logic [DBC_AW-1:0] dst;
      logic [DBC_AW-1:0] lar;
      logic [15:0] acc_left;
      logic eof_pend;
      logic [7:0] eof_stat;
      logic fidx;
      logic closed;
      dbc_mem_req_s mreq;
   } dbc_st_s;

   dbc_st_s q, d;
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic accepting;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [DBC_DW-1:0] fifo_out_data;
   dbc_ctl_s close_ctl;

   function automatic dbc_mem_req_s mem_op(input logic we, input logic [DBC_AW-1:0] addr,
                                           input logic [DBC_DW-1:0] wdata);
      dbc_mem_req_s r;
      r.req = 1'b1;
      r.we = we;
      r.addr = addr;
      r.wdata = wdata;
      return r;
   endfunction : mem_op

   // ==========================================
   // Reset release
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ==========================================
   // Data path
   assign accepting = (q.st == DBC_MOVE) && (q.acc_left != 16'h0000) && !q.eof_pend;
   assign o_per_ready = fifo_in_ready & accepting;
   assign fifo_out_ready = (q.st == DBC_MOVE) && !q.mreq.req;

   dbc_fifo #(.W(DBC_DW), .D(DBC_FIFO_DEPTH)) u_fifo (
      .i_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_in_valid(i_per_valid & accepting),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_per_data),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_out_ready),
      .o_out_data(fifo_out_data)
   );

   // ==========================================
   // Control
   always_comb begin
      d = q;
      d.closed = 1'b0;
      close_ctl = q.ctl;
      close_ctl.run = 1'b0;
      if (q.ctl.len != 16'h0000 && q.ctl.eof_en) begin
         close_ctl.cmd_status = q.eof_stat;
      end
      unique case (q.st)
         DBC_IDLE: begin
            if (i_sw_load) begin
               d.ctl = dbc_ctl_s'(i_sw_ctl);
               d.dst = i_sw_dst;
               d.lar = i_sw_lar;
               d.eof_pend = 1'b0;
               if (d.ctl.run && d.ctl.linked) begin
                  d.st = DBC_FETCH;
                  d.fidx = 1'b0;
                  d.mreq = mem_op(1'b0, i_sw_lar + DBC_OFS_CTL, '0);
               end else if (d.ctl.run) begin
                  d.st = DBC_MOVE;
                  d.acc_left = d.ctl.len;
               end
            end
         end
         DBC_FETCH: begin
            if (!q.mreq.req) begin
               d.mreq = mem_op(1'b0, q.lar + DBC_OFS_DST, '0);
            end else if (i_mem_ack) begin
               d.mreq.req = 1'b0;
               if (!q.fidx) begin
                  d.ctl = dbc_ctl_s'(i_mem_rdata);
                  d.fidx = 1'b1;
               end else begin
                  d.dst = i_mem_rdata;
                  d.eof_pend = 1'b0;
                  d.acc_left = q.ctl.len;
                  d.st = q.ctl.run ? DBC_MOVE : DBC_IDLE;
               end
            end
         end
         DBC_MOVE: begin
            if (o_per_ready && i_per_valid) begin
               d.acc_left = q.acc_left - 16'h0001;
            end
            if (i_per_eof && !q.eof_pend) begin
               d.eof_pend = 1'b1;
               d.eof_stat = i_per_status;
            end
            if (q.mreq.req) begin
               if (i_mem_ack) begin
                  d.mreq.req = 1'b0;
                  d.dst = q.dst + DBC_UNIT_STEP;
                  d.ctl.len = q.ctl.len - 16'h0001;
               end
            end else if (fifo_out_valid) begin
               d.mreq = mem_op(1'b1, q.dst, fifo_out_data);
            end else if (q.ctl.len == 16'h0000 || q.eof_pend) begin
               d.ctl = close_ctl;
               if (q.ctl.linked && !q.ctl.loop) begin
                  d.st = DBC_WB;
                  d.mreq = mem_op(1'b1, q.lar + DBC_OFS_CTL, close_ctl);
               end else begin
                  d.st = DBC_LARSTEP;
               end
            end
         end
         DBC_WB: begin
            if (i_mem_ack) begin
               d.mreq.req = 1'b0;
               d.st = DBC_LARSTEP;
            end
         end
         DBC_LARSTEP: begin
            if (q.ctl.link_fetch) begin
               d.st = DBC_NEXTLAR;
               d.mreq = mem_op(1'b0, q.lar + DBC_OFS_NEXT, '0);
            end else begin
               d.lar = q.lar + DBC_DESC_STEP;
               d.st = DBC_RELOAD;
            end
         end
         DBC_NEXTLAR: begin
            if (i_mem_ack) begin
               d.mreq.req = 1'b0;
               d.lar = i_mem_rdata;
               d.st = DBC_RELOAD;
            end
         end
         DBC_RELOAD: begin
            d.closed = 1'b1;
            if (q.ctl.linked) begin
               d.st = DBC_FETCH;
               d.fidx = 1'b0;
               d.mreq = mem_op(1'b0, q.lar + DBC_OFS_CTL, '0);
            end else begin
               d.st = DBC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= DBC_IDLE;
         q.ctl <= dbc_ctl_s'(DBC_CTL_RST);
         q.dst <= DBC_ADDR_RST;
         q.lar <= DBC_ADDR_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================
   // Outputs
   assign o_channel_control_word = q.ctl;
   assign o_dst = q.dst;
   assign o_list_address_pointer = q.lar;
   assign o_busy = (q.st != DBC_IDLE);
   assign o_closed = q.closed;
   assign o_mem_req = q.mreq.req;
   assign o_mem_we = q.mreq.we;
   assign o_mem_addr = q.mreq.addr;
   assign o_mem_wdata = q.mreq.wdata;
endmodule : dbc_channel

// ==== dbc_chk.sv ====
// Port checker for the DMA buffer closure channel
`timescale 1ns/100ps
module dbc_chk
   import dbc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [31:0] o_channel_control_word,
   input wire logic [DBC_AW-1:0] o_dst,
   input wire logic o_busy,
   input wire logic o_closed,
   input wire logic o_per_ready,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic [DBC_AW-1:0] o_mem_addr,
   input wire logic i_mem_ack
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   logic wr_ack;
   logic [15:0] len;
   assign len = o_channel_control_word[31:16];
   // Data write accepted by memory
   assign wr_ack = o_mem_req && o_mem_we && i_mem_ack && o_mem_addr == o_dst;
   AST_REQ_HOLD: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
      else $error("request moved before ack");
   AST_REQ_DROP: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
      else $error("request held after ack");
   AST_LEN_DEC: assert property (wr_ack |=> len == $past(len) - 16'h1)
      else $error("length not decremented");
   AST_DST_STEP: assert property (wr_ack |=> o_dst == $past(o_dst) + DBC_UNIT_STEP)
      else $error("destination not stepped");
   AST_LEN_ZERO: assert property (len == 16'h0 |-> !o_per_ready)
      else $error("ready with zero length");
   AST_RUN_CLR: assert property (o_closed |-> !o_channel_control_word[0])
      else $error("run bit set at closure");
   AST_ONE_CLOSE: assert property (o_closed |=> !o_closed)
      else $error("closure repeated");
   AST_IDLE_STOP: assert property (!o_busy |-> !o_per_ready && !o_mem_req)
      else $error("activity while idle");
endmodule : dbc_chk

// ==== dbc_mem.sv ====
// Behavioural system memory on the channel's memory port
`timescale 1ns/100ps
module dbc_mem
   import dbc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [DBC_AW-1:0] i_addr,
   input wire logic [DBC_DW-1:0] i_wdata,
   output logic o_ack,
   output logic [DBC_DW-1:0] o_rdata
);
   logic [DBC_DW-1:0] mem [64];
   logic [3:0] cyc = 4'h0;
   logic [1:0] wait_q = 2'h0;
   logic ack_q = 1'b0;
   assign o_ack = ack_q;
   // Moving pattern outside the ack cycle
   assign o_rdata = ack_q ? mem[i_addr[7:2]] : {8{cyc}};
   always @(posedge i_clk) begin
      cyc <= cyc + 4'h1;
      ack_q <= 1'b0;
      if (i_req && !ack_q) begin
         if (wait_q == 2'h0) begin
            ack_q <= 1'b1;
            wait_q <= cyc[1:0];
            if (i_we) begin
               mem[i_addr[7:2]] <= i_wdata;
            end
         end else begin
            wait_q <= wait_q - 2'h1;
         end
      end
   end
endmodule : dbc_mem

// ==== dbc_tb.sv ====
// Self-checking testbench for the DMA buffer closure channel
`timescale 1ns/100ps
module testbench
   import dbc_pkg::*;
;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_sw_load = 1'b0;
   logic [31:0] i_sw_ctl = 32'h0, i_sw_dst = 32'h0, i_sw_lar = 32'h0;
   logic i_per_valid = 1'b0, i_per_eof = 1'b0;
   logic [31:0] i_per_data = 32'h0;
   logic [7:0] i_per_status = 8'h0;
   logic [31:0] o_channel_control_word, o_dst, o_list_address_pointer;
   logic [31:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
   logic o_busy, o_closed, o_per_ready, o_mem_req, o_mem_we, i_mem_ack;
   int num_errors = 0;
   int total_checks = 0;
   always #2.5 i_core_clk = ~i_core_clk;
   dbc_channel uut (.i_core_clk, .i_nrst, .i_sw_load, .i_sw_ctl, .i_sw_dst, .i_sw_lar,
      .o_channel_control_word, .o_dst, .o_list_address_pointer, .o_busy, .o_closed,
      .i_per_valid, .i_per_data, .o_per_ready, .i_per_eof, .i_per_status, .o_mem_req,
      .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata);
   dbc_mem mem_i (.i_clk(i_core_clk), .i_req(o_mem_req), .i_we(o_mem_we),
      .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
   // ==========================================
   // Tasks
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask : chk
   // 0: ready, 1: closure pulse, 2: idle
   task automatic wait_for(input int w);
      for (int n = 0; n < 300; n++) begin
         @(negedge i_core_clk);
         if (w == 0 ? o_per_ready === 1'b1 : w == 1 ? o_closed === 1'b1 : o_busy === 1'b0) begin
            return;
         end
      end
      num_errors++;
      wrap_up();
   endtask : wait_for
   task automatic load(input logic [31:0] c, input logic [31:0] d, input logic [31:0] l);
      @(posedge i_core_clk);
      i_sw_load <= 1'b1;
      i_sw_ctl <= c;
      i_sw_dst <= d;
      i_sw_lar <= l;
      @(posedge i_core_clk);
      i_sw_load <= 1'b0;
   endtask : load
   task automatic send(input logic [31:0] d, input logic eof);
      i_per_valid <= 1'b1;
      i_per_data <= d;
      i_per_eof <= eof;
      wait_for(0);
      @(posedge i_core_clk);
   endtask : send
   function automatic logic [31:0] closed_ctl(input logic [31:0] c, input logic [15:0] rem,
      input logic [7:0] cs);
      return {rem, cs, c[7:1], 1'b0};
   endfunction : closed_ctl
   // ==========================================
   // Main sequence
   initial begin
      logic [31:0] c;
      logic [31:0] data [4];
      logic [7:0] st;
      int len;
      int k;
      k = $urandom(30);
      repeat (3) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      // Direct: normal, early eof with and without eof_en, eof on last word
      for (int m = 0; m < 4; m++) begin
         len = 2 + $urandom % 3;
         k = (m == 1 || m == 2) ? 1 : len;
         st = 8'($urandom);
         i_per_status <= st;
         c = {len[15:0], 8'h5A, 3'h0, 2'h0, m != 2, 2'h1};
         load(c, 32'h0, 32'h40);
         if (m == 0) load(32'hFFFF_FFFF, 32'h80, 32'h0);
         for (int j = 0; j < k; j++) begin
            data[j] = $urandom;
            send(data[j], m == 3 && j == k - 1);
         end
         i_per_valid <= 1'b0;
         i_per_eof <= k < len;
         @(posedge i_core_clk);
         i_per_eof <= 1'b0;
         wait_for(1);
         chk(o_channel_control_word, closed_ctl(c, 16'(len - k), m == 1 ? st : 8'h5A));
         chk(o_list_address_pointer, 32'h4C);
         chk(o_dst, 32'(4 * k));
         wait_for(2);
         for (int j = 0; j < k; j++) chk(mem_i.mem[j], data[j]);
      end
      // Linked: link fetch, then loop descriptor, then stop descriptor
      mem_i.mem[18] = 32'h80;
      mem_i.mem[32] = 32'h0001_3313;
      mem_i.mem[33] = 32'h20;
      mem_i.mem[35] = 32'h0;
      mem_i.mem[36] = 32'h0;
      c = 32'h0002_C319;
      mem_i.mem[16] = c;
      mem_i.mem[17] = 32'h10;
      load(c, 32'h10, 32'h40);
      for (int j = 0; j < 3; j++) begin
         data[j] = $urandom;
         if (j == 2) begin
            wait_for(1);
            chk(mem_i.mem[16], closed_ctl(c, 16'h0, 8'hC3));
            chk(o_list_address_pointer, 32'h80);
            @(posedge i_core_clk);
         end
         send(data[j], 1'b0);
         if (j == 1) i_per_valid <= 1'b0;
      end
      i_per_valid <= 1'b0;
      wait_for(1);
      chk(o_list_address_pointer, 32'h8C);
      chk(mem_i.mem[32], 32'h0001_3313);
      wait_for(2);
      chk(mem_i.mem[4], data[0]);
      chk(mem_i.mem[5], data[1]);
      chk(mem_i.mem[8], data[2]);
      wrap_up();
   end
endmodule : testbench
bind dbc_channel dbc_chk chk_i (.i_core_clk, .i_nrst, .o_channel_control_word, .o_dst,
   .o_busy, .o_closed, .o_per_ready, .o_mem_req, .o_mem_we, .o_mem_addr, .i_mem_ack);
